// ---- core/detach_regs_pkg.sv ----
package detach_regs_pkg;
  // ****************************************************************
  // Register indices as printed; byte address is four times the index.
  // ****************************************************************
  localparam int unsigned  CHANNELS        = 8;
  localparam logic [7:0]   IDX_POS_SENSE   = 8'h0f;
  localparam logic [7:0]   IDX_NEG_SENSE   = 8'h10;
  localparam logic [7:0]   IDX_PULL_REV    = 8'h11;
  localparam logic [7:0]   IDX_POS_FLAGS   = 8'h12;
  localparam logic [7:0]   IDX_NEG_FLAGS   = 8'h13;
  localparam logic [7:0]   IDX_IRQ_STATUS  = 8'h20;
  localparam logic [7:0]   IDX_IRQ_MASK    = 8'h21;
  localparam logic [7:0]   RESET_BYTE      = 8'h00;
  localparam logic [15:0]  RESET_IRQ       = 16'h0000;
  localparam int unsigned  ADDR_W          = 8;
  // ****************************************************************
  // Bus answers.
  // ****************************************************************
  localparam logic [1:0]   RESP_OKAY       = 2'b00;
  localparam logic [1:0]   RESP_SLVERR     = 2'b10;
endpackage

// ---- core/detach_sync.sv ----
`timescale 1ns/1ps
// Two-flop synchroniser for one comparator level.
module detach_sync
  import detach_regs_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ---- core/lead_off_flip_and_status_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// - An eight-bit read/write pull reverse register has bit n-1 for channel n and resets to zero.
// - With a reverse bit at 0 the positive input pulls high and the negative input pulls low.
// - With a reverse bit at 1 the positive input pulls low and the negative input pulls high.
// - A read-only positive detach flag register sits at index 12h, resets to 00h, bit n-1 for channel n.
// - A read-only negative detach flag register sits at index 13h, resets to 00h, bit n-1 for channel n.
// - A flag reads 1 when detached and 0 when attached, and writes never change it.
// - The pull reverse register sits at index 11h and resets to 00h.
// - Positive sense enables sit at index 0Fh and negative ones at 10h, bit n-1 for channel n.
module lead_off_flip_and_status_regs
  import detach_regs_pkg::*;
#(
  parameter int unsigned N = CHANNELS
)
(
  input  wire logic               core_clk,
  input  wire logic               rstn,
  input  wire logic [ADDR_W+1:0]  s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W+1:0]  s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [N-1:0]       pos_comparator,
  input  wire logic [N-1:0]       neg_comparator,
  output logic [N-1:0]            pos_pull_high,
  output logic [N-1:0]            neg_pull_high,
  output logic [N-1:0]            pos_detach_sense_enables,
  output logic [N-1:0]            neg_detach_sense_enables,
  output logic                    irq
);
  // ****************************************************************
  // State.
  // ****************************************************************
  logic [N-1:0]    detach_pull_reverse, next_detach_pull_reverse;
  logic [N-1:0]    pos_sense, next_pos_sense;
  logic [N-1:0]    neg_sense, next_neg_sense;
  logic [N-1:0]    pos_detach_flags, neg_detach_flags;
  logic [N-1:0]    pos_sync, neg_sync;
  logic [2*N-1:0]  irq_status, next_irq_status;
  logic [2*N-1:0]  irq_mask, next_irq_mask;
  logic            aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_idx, next_aw_idx;
  logic [31:0]     w_data, next_w_data;
  logic [3:0]      w_strb, next_w_strb;
  logic            bvalid_q, next_bvalid;
  logic [1:0]      bresp_q, next_bresp;
  logic            rvalid_q, next_rvalid;
  logic [31:0]     rdata_q, next_rdata;
  logic [1:0]      rresp_q, next_rresp;
  logic [N-1:0]    next_pos_high, next_neg_high;
  logic            next_irq;

  // ****************************************************************
  // Comparator capture.
  // ****************************************************************
  // Comparators are analog, so each level is synchronised before use.
  for (genvar i = 0; i < N; i++) begin : g_sync
    detach_sync u_pos (.core_clk(core_clk), .rstn(rstn), .async_in(pos_comparator[i]), .sync_out(pos_sync[i]));
    detach_sync u_neg (.core_clk(core_clk), .rstn(rstn), .async_in(neg_comparator[i]), .sync_out(neg_sync[i]));
  end

  // Flags hold the latest synchronised comparator state; the bus never writes them.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pos_detach_flags <= RESET_BYTE;
      neg_detach_flags <= RESET_BYTE;
    end else begin
      pos_detach_flags <= pos_sync;
      neg_detach_flags <= neg_sync;
    end
  end

  // ****************************************************************
  // Bus slave and register next state.
  // ****************************************************************
  // Address and data are latched independently, so either may come first.
  always_comb begin
    logic            do_write;
    logic [31:0]     wd;
    logic [ADDR_W-1:0] ridx;
    logic [2*N-1:0]  evt;
    do_write = 1'b0;
    wd = 32'h0000_0000;
    ridx = '0;
    evt = '0;
    next_aw_held = aw_held;
    next_aw_idx = aw_idx;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid_q;
    next_bresp = bresp_q;
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    next_detach_pull_reverse = detach_pull_reverse;
    next_pos_sense = pos_sense;
    next_neg_sense = neg_sense;
    next_irq_mask = irq_mask;
    // Beats are taken only while the registered ready is shown, so nothing is taken
    // in the first cycle after reset, when the readies are still low.
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx = s_axi_awaddr[ADDR_W+1:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid_q) begin
      do_write = 1'b1;
      wd = w_data;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_idx == IDX_PULL_REV) begin
        if (w_strb[0]) next_detach_pull_reverse = wd[N-1:0];
      end else if (aw_idx == IDX_POS_SENSE) begin
        if (w_strb[0]) next_pos_sense = wd[N-1:0];
      end else if (aw_idx == IDX_NEG_SENSE) begin
        if (w_strb[0]) next_neg_sense = wd[N-1:0];
      end else if (aw_idx == IDX_IRQ_MASK) begin
        if (w_strb[0]) next_irq_mask[7:0] = wd[7:0];
        if (w_strb[1]) next_irq_mask[15:8] = wd[15:8];
      end else if (aw_idx == IDX_POS_FLAGS || aw_idx == IDX_NEG_FLAGS || aw_idx == IDX_IRQ_STATUS) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end
    // Events are new detaches on enabled inputs; set wins over a clear.
    evt = {neg_sync & ~neg_detach_flags & neg_sense, pos_sync & ~pos_detach_flags & pos_sense};
    next_irq_status = irq_status;
    if (do_write && aw_idx == IDX_IRQ_STATUS) begin
      if (w_strb[0]) next_irq_status[7:0] = irq_status[7:0] & ~wd[7:0];
      if (w_strb[1]) next_irq_status[15:8] = irq_status[15:8] & ~wd[15:8];
    end
    next_irq_status = next_irq_status | evt;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ridx = s_axi_araddr[ADDR_W+1:2];
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (ridx == IDX_PULL_REV) begin
        next_rdata[N-1:0] = detach_pull_reverse;
      end else if (ridx == IDX_POS_SENSE) begin
        next_rdata[N-1:0] = pos_sense;
      end else if (ridx == IDX_NEG_SENSE) begin
        next_rdata[N-1:0] = neg_sense;
      end else if (ridx == IDX_POS_FLAGS) begin
        next_rdata[N-1:0] = pos_detach_flags;
      end else if (ridx == IDX_NEG_FLAGS) begin
        next_rdata[N-1:0] = neg_detach_flags;
      end else if (ridx == IDX_IRQ_STATUS) begin
        next_rdata[2*N-1:0] = irq_status;
      end else if (ridx == IDX_IRQ_MASK) begin
        next_rdata[2*N-1:0] = irq_mask;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    // Pull direction per input follows the reverse bit directly.
    next_pos_high = ~next_detach_pull_reverse;
    next_neg_high = next_detach_pull_reverse;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // Registers only; ready outputs are registered; awready and wready drop while a beat is held, arready while a read response is pending.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held <= 1'b0;
      aw_idx <= '0;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      detach_pull_reverse <= RESET_BYTE;
      pos_sense <= RESET_BYTE;
      neg_sense <= RESET_BYTE;
      irq_status <= RESET_IRQ;
      irq_mask <= RESET_IRQ;
      pos_pull_high <= {N{1'b1}};
      neg_pull_high <= '0;
      irq <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid_q <= next_bvalid;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
      detach_pull_reverse <= next_detach_pull_reverse;
      pos_sense <= next_pos_sense;
      neg_sense <= next_neg_sense;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      pos_pull_high <= next_pos_high;
      neg_pull_high <= next_neg_high;
      irq <= next_irq;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      s_axi_arready <= !next_rvalid;
    end
  end

  // ****************************************************************
  // Output wiring.
  // ****************************************************************
  // These are the registered values themselves.
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign pos_detach_sense_enables = pos_sense;
  assign neg_detach_sense_enables = neg_sense;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_pull_opposite;
    @(posedge core_clk) disable iff (!rstn) pos_pull_high == ~neg_pull_high;
  endproperty
  a_pull_opposite: assert property (p_pull_opposite) else $error("pull sides not opposite");

  property p_pull_follows;
    @(posedge core_clk) disable iff (!rstn) neg_pull_high == $past(next_detach_pull_reverse);
  endproperty
  a_pull_follows: assert property (p_pull_follows) else $error("pull does not follow reverse bits");

  property p_pos_capture;
    @(posedge core_clk) disable iff (!rstn) ##1 pos_detach_flags == $past(pos_sync);
  endproperty
  a_pos_capture: assert property (p_pos_capture) else $error("positive flags stale");

  property p_neg_capture;
    @(posedge core_clk) disable iff (!rstn) ##1 neg_detach_flags == $past(neg_sync);
  endproperty
  a_neg_capture: assert property (p_neg_capture) else $error("negative flags stale");

  property p_read_pos;
    @(posedge core_clk) disable iff (!rstn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W+1:2] == IDX_POS_FLAGS)
      |=> (s_axi_rvalid && s_axi_rdata[N-1:0] == $past(pos_detach_flags) && s_axi_rdata[31:N] == '0);
  endproperty
  a_read_pos: assert property (p_read_pos) else $error("positive flag read wrong");

  property p_read_neg;
    @(posedge core_clk) disable iff (!rstn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W+1:2] == IDX_NEG_FLAGS)
      |=> (s_axi_rvalid && s_axi_rdata[N-1:0] == $past(neg_detach_flags));
  endproperty
  a_read_neg: assert property (p_read_neg) else $error("negative flag read wrong");

  property p_write_rev;
    @(posedge core_clk) disable iff (!rstn)
      (aw_held && w_held && !bvalid_q && aw_idx == IDX_PULL_REV && w_strb[0])
      |=> (detach_pull_reverse == $past(w_data[N-1:0]) && s_axi_bvalid);
  endproperty
  a_write_rev: assert property (p_write_rev) else $error("reverse register write lost");

  property p_irq_level;
    @(posedge core_clk) disable iff (!rstn) ##1 irq == |($past(next_irq_status) & $past(next_irq_mask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import detach_regs_pkg::*;
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W+1:0] awaddr = '0, araddr = '0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0]       wdata = '0, rdata, rd;
  logic [3:0]        wstrb = 4'hf;
  logic [1:0]        bresp, rresp, rsp;
  logic [7:0]        pos_cmp = '0, neg_cmp = '0, pos_hi, neg_hi, pos_en, neg_en;
  logic [7:0]        pats [3] = '{8'h01, 8'h80, 8'ha5};
  int                num_errors = 0;
  int                cmp_count = 0;
  int                cycles = 0;

  lead_off_flip_and_status_regs #(.N(CHANNELS)) uut (
    .core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pos_comparator(pos_cmp), .neg_comparator(neg_cmp),
    .pos_pull_high(pos_hi), .neg_pull_high(neg_hi),
    .pos_detach_sense_enables(pos_en), .neg_detach_sense_enables(neg_en), .irq(irq));

  // ****************************************************************
  // Clock, timeout and verdict.
  // ****************************************************************
  // The clock toggles every 5 ns, a half period of the 10 ns period.
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // A hung handshake would stall forever, so a cycle ceiling ends the run.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One comparison; case inequality keeps unknowns from matching.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ****************************************************************
  // Bus tasks.
  // ****************************************************************
  // Address and data are offered together; each is dropped once taken.
  task automatic bus_write(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    awaddr  <= {idx, 2'b00};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end while (!done);
  endtask

  task automatic bus_read(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge core_clk);
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end while (!done);
  endtask

  task automatic read_check(input logic [7:0] idx, input logic [31:0] exp);
    bus_read(idx, rd, rsp);
    check(rd, exp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  // Reset is held four cycles; requests start on the third edge after release.
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check({24'h0, pos_hi}, 32'h0000_00ff);
    check({24'h0, neg_hi}, 32'h0);
    check({31'h0, irq}, 32'h0);
    read_check(IDX_PULL_REV, 32'h0);
    read_check(IDX_POS_FLAGS, 32'h0);
    read_check(IDX_NEG_FLAGS, 32'h0);
    read_check(IDX_POS_SENSE, 32'h0);
    read_check(IDX_NEG_SENSE, 32'h0);
    read_check(IDX_IRQ_STATUS, 32'h0);
    // Single-channel patterns 01h and 80h catch a reversed bit order in the pull mapping; a5h sets several channels.
    for (int i = 0; i < 3; i++) begin
      bus_write(IDX_PULL_REV, {24'h0, pats[i]}, rsp);
      read_check(IDX_PULL_REV, {24'h0, pats[i]});
      check({24'h0, pos_hi}, {24'h0, ~pats[i]});
      check({24'h0, neg_hi}, {24'h0, pats[i]});
    end
    bus_write(IDX_POS_SENSE, 32'h0000_00ff, rsp);
    bus_write(IDX_NEG_SENSE, 32'h0000_00ff, rsp);
    check({16'h0, neg_en, pos_en}, 32'h0000_ffff);
    // Comparators change only after the enables so the events count.
    @(posedge core_clk);
    pos_cmp <= 8'h81;
    neg_cmp <= 8'h3c;
    repeat (5) @(posedge core_clk);
    read_check(IDX_POS_FLAGS, 32'h0000_0081);
    read_check(IDX_NEG_FLAGS, 32'h0000_003c);
    bus_write(IDX_POS_FLAGS, 32'h0000_0000, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    bus_write(IDX_NEG_FLAGS, 32'h0000_00ff, rsp);
    read_check(IDX_POS_FLAGS, 32'h0000_0081);
    read_check(IDX_NEG_FLAGS, 32'h0000_003c);
    // Unmapped index is refused and leaves nothing behind.
    bus_write(8'h05, 32'h0000_00ff, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    bus_read(8'h05, rd, rsp);
    check(rd, 32'h0);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Interrupt: held off by the mask, raised when unmasked, cleared by write-one.
    read_check(IDX_IRQ_STATUS, 32'h0000_3c81);
    check({31'h0, irq}, 32'h0);
    bus_write(IDX_IRQ_MASK, 32'h0000_ffff, rsp);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h1);
    bus_write(IDX_IRQ_STATUS, 32'h0000_3c81, rsp);
    @(posedge core_clk);
    read_check(IDX_IRQ_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    // Electrodes reattach and the flags follow.
    pos_cmp <= 8'h00;
    neg_cmp <= 8'h00;
    repeat (5) @(posedge core_clk);
    read_check(IDX_POS_FLAGS, 32'h0);
    read_check(IDX_NEG_FLAGS, 32'h0);
    give_verdict();
  end
endmodule
